// file: common/flyby_dma_pkg.sv
package flyby_dma_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_DMA_REQ   = 8'h00;
  localparam logic [7:0] OFS_PAGE_SEL  = 8'h04;
  localparam logic [7:0] OFS_LOC_CTL   = 8'h08;
  localparam logic [7:0] OFS_EP_SETUP  = 8'h0C;
  localparam logic [7:0] OFS_XFER_CNT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_DMA_STATE = 8'h18;

  // Field positions in the plain bit registers
  localparam int SPLIT_BIT = 0;
  localparam int DONE_BIT  = 0;

  // Endpoint codes
  localparam logic [1:0] EP_ZERO = 2'h0;
  localparam logic [1:0] EP_A    = 2'h1;
  localparam logic [1:0] EP_B    = 2'h2;
  localparam logic [1:0] EP_C    = 2'h3;

  // Values after reset
  localparam logic [10:0] RST_MAX_PKT = 11'h040;
  localparam logic [15:0] RST_XFER    = 16'h0000;

  // Request timing at the 100 ns clock
  localparam int CLK_NS   = 100;
  localparam int T20_NS   = 40;
  localparam int T21_NS   = 16;
  localparam int T20_CYC  = (T20_NS / CLK_NS < 1) ? 1 : T20_NS / CLK_NS;
  localparam int T21_CYC  = (T21_NS / CLK_NS < 1) ? 1 : T21_NS / CLK_NS;
  localparam logic [3:0] REARM_CYC = 4'(T21_CYC);

  // DMA request register layout: bit 0 enable, bits 2:1 endpoint, bit 3 qualify
  typedef struct packed {
    logic       ack_qualify_mode_bit;
    logic [1:0] ep;
    logic       en;
  } dma_ctrl_t;

  // Endpoint configuration: bit 0 direction (1 = device to host), bits 11:1 max packet
  typedef struct packed {
    logic [10:0] max_pkt;
    logic        dir_in;
  } ep_setup_t;

  // Local-bus DMA pins as they arrive, all asynchronous
  typedef struct packed {
    logic        ack_n;
    logic        term_n;
    logic        hrd_n;
    logic        hwr_n;
    logic        drd_n;
    logic        dwr_n;
    logic [15:0] data;
  } dma_pins_t;

  typedef enum logic [1:0] {S_IDLE, S_CYCLE, S_GAP} dma_state_t;

endpackage

// file: design/usb_endpoint_flyby_dma_port.sv
`timescale 1ns/100ps
module usb_endpoint_flyby_dma_port (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // DMA pins
  output logic             dma_request_out,
  input  wire logic        dma_acknowledge_in_n,
  input  wire logic        end_of_transfer_in_n,
  input  wire logic        host_read_strobe_n,
  input  wire logic        host_write_strobe_n,
  input  wire logic        split_dma_read_strobe_n,
  input  wire logic        split_dma_write_strobe_n,
  input  wire logic [15:0] local_data_bus_in,
  output logic      [15:0] local_data_bus_out,
  output logic      [15:0] local_data_bus_oe,
  // Endpoint packet buffers
  input  wire logic [3:0]  buf_has_data,
  input  wire logic [3:0]  buf_has_space,
  input  wire logic [7:0]  buf_rdata,
  output logic      [1:0]  buf_sel,
  output logic             buf_pop,
  output logic             buf_push,
  output logic      [7:0]  buf_wdata,
  output logic             buf_validate
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  flyby_dma_pkg::dma_pins_t  sync1_q, sync2_q;
  flyby_dma_pkg::dma_ctrl_t  ctrl_q, ctrl_d;
  flyby_dma_pkg::ep_setup_t  cfg_q [4];
  flyby_dma_pkg::ep_setup_t  cfg_d [4];
  flyby_dma_pkg::dma_state_t state_q, state_d;
  logic [1:0]  page_q, page_d;
  logic        split_q, split_d;
  logic [15:0] cnt_q, cnt_d;
  logic [10:0] pkt_q, pkt_d;
  logic [3:0]  gap_q, gap_d;
  logic        done_q, done_d;
  logic        term_q, term_d;
  logic        req_q, req_d;
  logic [7:0]  dout_q, dout_d;
  logic        doe_q, doe_d;
  logic        pop_q, pop_d;
  logic        push_q, push_d;
  logic [7:0]  wdat_q, wdat_d;
  logic        val_q, val_d;
  logic [1:0]  bsel_q, bsel_d;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] lbo_q, lbo_d;
  logic [15:0] lbe_q, lbe_d;

  flyby_dma_pkg::ep_setup_t dma_cfg;
  logic        ep_ok, strobe, act, avail, req_ok, dma_dec, addr_ok, cycle_end;
  logic [7:0]  din;

  ////////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    ctrl_d    = ctrl_q;
    cfg_d     = cfg_q;
    state_d   = state_q;
    page_d    = page_q;
    split_d   = split_q;
    cnt_d     = cnt_q;
    pkt_d     = pkt_q;
    gap_d     = gap_q;
    done_d    = done_q;
    term_d    = term_q;
    dout_d    = dout_q;
    doe_d     = doe_q;
    pop_d     = 1'b0;
    push_d    = 1'b0;
    wdat_d    = wdat_q;
    val_d     = 1'b0;
    dma_dec   = 1'b0;

    ep_ok   = (ctrl_q.ep == flyby_dma_pkg::EP_A) || (ctrl_q.ep == flyby_dma_pkg::EP_B);
    dma_cfg = cfg_q[ctrl_q.ep];
    // Strobe pair depends on direction and on split mode
    if (dma_cfg.dir_in) begin
      strobe = split_q ? ~sync2_q.dwr_n : ~sync2_q.hwr_n;
    end else begin
      strobe = split_q ? ~sync2_q.drd_n : ~sync2_q.hrd_n;
    end
    act = ~sync2_q.ack_n & (~ctrl_q.ack_qualify_mode_bit | strobe);
    din = split_q ? sync2_q.data[15:8] : sync2_q.data[7:0];
    cycle_end = (state_q == flyby_dma_pkg::S_CYCLE) && !act;

    // Availability: OUT needs unread data, IN needs space and owed bytes
    if (dma_cfg.dir_in) begin
      avail = buf_has_space[ctrl_q.ep] && (cnt_q != 16'h0000);
    end else begin
      avail = buf_has_data[ctrl_q.ep];
    end
    req_ok = ctrl_q.en && ep_ok && avail;

    // Fly-by cycle sequencer
    unique case (state_q)
      flyby_dma_pkg::S_IDLE: begin
        if (act) begin
          state_d = flyby_dma_pkg::S_CYCLE;
          term_d  = ~sync2_q.term_n;
          if (!dma_cfg.dir_in) begin
            dout_d = buf_rdata;
            doe_d  = 1'b1;
          end else begin
            wdat_d = din;
          end
        end
      end
      flyby_dma_pkg::S_CYCLE: begin
        // End-of-transfer only counts inside a qualified cycle
        if (act && !sync2_q.term_n) begin
          term_d = 1'b1;
        end
        // Latch while qualified: data and acknowledge are released together
        if (act && dma_cfg.dir_in) begin
          wdat_d = din;
        end
        if (!act) begin
          // Cycle completes even if software dropped the enable meanwhile
          state_d = flyby_dma_pkg::S_GAP;
          gap_d   = flyby_dma_pkg::REARM_CYC;
          doe_d   = 1'b0;
          if (dma_cfg.dir_in) begin
            push_d  = 1'b1;
            dma_dec = 1'b1;
            if (cnt_q != 16'h0000) begin
              cnt_d = cnt_q - 16'h0001;
            end
            if (pkt_q + 11'h001 >= dma_cfg.max_pkt) begin
              val_d = 1'b1;
              pkt_d = 11'h000;
            end else begin
              pkt_d = pkt_q + 11'h001;
            end
            if (cnt_q == 16'h0001) begin
              val_d          = 1'b1;
              pkt_d          = 11'h000;
              done_d         = 1'b1;
              ctrl_d.en      = 1'b0;
            end
          end else begin
            pop_d = 1'b1;
          end
          if (term_q) begin
            ctrl_d.en = 1'b0;
            done_d    = 1'b1;
            if (dma_cfg.dir_in) begin
              val_d = 1'b1;
              pkt_d = 11'h000;
            end
          end
        end
      end
      flyby_dma_pkg::S_GAP: begin
        term_d = 1'b0;
        if (gap_q <= 4'h1) begin
          state_d = flyby_dma_pkg::S_IDLE;
        end else begin
          gap_d = gap_q - 4'h1;
        end
      end
    endcase

    // Request is dropped as soon as a cycle is seen, raised again after the gap
    req_d = req_ok && (state_q == flyby_dma_pkg::S_IDLE) && !act;

    // AHB-Lite: address phase capture, write in data phase
    addr_ok   = (haddr[1:0] == 2'b00) && (haddr[31:8] == 24'h00_0000);
    wr_pend_d = hsel && hready && htrans[1] && hwrite && addr_ok;
    wr_addr_d = haddr[7:0];
    rdata_d   = rdata_q;
    if (hsel && hready && htrans[1] && !hwrite) begin
      rdata_d = 32'h0000_0000;
      if (addr_ok) begin
        unique case (haddr[7:0])
          flyby_dma_pkg::OFS_DMA_REQ:   rdata_d[3:0]  = ctrl_q;
          flyby_dma_pkg::OFS_PAGE_SEL:  rdata_d[1:0]  = page_q;
          flyby_dma_pkg::OFS_LOC_CTL:   rdata_d[flyby_dma_pkg::SPLIT_BIT] = split_q;
          flyby_dma_pkg::OFS_EP_SETUP:  rdata_d[11:0] = cfg_q[page_q];
          flyby_dma_pkg::OFS_XFER_CNT:  rdata_d[15:0] = cnt_q;
          flyby_dma_pkg::OFS_IRQ_STAT:  rdata_d[flyby_dma_pkg::DONE_BIT] = done_q;
          flyby_dma_pkg::OFS_DMA_STATE: rdata_d[15:0] = {req_q, 1'b0, state_q, 1'b0, pkt_q};
          default:                      rdata_d       = 32'h0000_0000;
        endcase
      end
    end
    if (wr_pend_q) begin
      unique case (wr_addr_q)
        flyby_dma_pkg::OFS_DMA_REQ: begin
          // A hardware clear in the same cycle wins over a software set
          ctrl_d.ack_qualify_mode_bit = hwdata[3];
          ctrl_d.ep                   = hwdata[2:1];
          ctrl_d.en                   = hwdata[0] && !(ctrl_q.en && !ctrl_d.en);
        end
        flyby_dma_pkg::OFS_PAGE_SEL: page_d = hwdata[1:0];
        // Config writes follow page select, so they may run beside split DMA
        flyby_dma_pkg::OFS_LOC_CTL:  split_d = hwdata[flyby_dma_pkg::SPLIT_BIT];
        flyby_dma_pkg::OFS_EP_SETUP: cfg_d[page_q] = hwdata[11:0];
        flyby_dma_pkg::OFS_XFER_CNT: begin
          cnt_d = hwdata[15:0];
          if (hwdata[15:0] == 16'h0000) begin
            val_d = 1'b1;
            pkt_d = 11'h000;
          end
        end
        flyby_dma_pkg::OFS_IRQ_STAT: begin
          // Write one to clear; a new done event in the same cycle wins
          if (hwdata[flyby_dma_pkg::DONE_BIT] && !(done_d && !done_q)) begin
            done_d = 1'b0;
          end
        end
        default: ;
      endcase
    end

    bsel_d = ctrl_d.en ? ctrl_d.ep : page_d;
    lbo_d  = split_d ? {dout_d, 8'h00} : {8'h00, dout_d};
    lbe_d  = doe_d ? (split_d ? 16'hFF00 : 16'h00FF) : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q   <= '1;
      sync2_q   <= '1;
      ctrl_q    <= '0;
      for (int i = 0; i < 4; i++) begin
        cfg_q[i] <= '{max_pkt: flyby_dma_pkg::RST_MAX_PKT, dir_in: 1'b0};
      end
      state_q   <= flyby_dma_pkg::S_IDLE;
      page_q    <= flyby_dma_pkg::EP_ZERO;
      split_q   <= 1'b0;
      cnt_q     <= flyby_dma_pkg::RST_XFER;
      pkt_q     <= 11'h000;
      gap_q     <= 4'h0;
      done_q    <= 1'b0;
      term_q    <= 1'b0;
      req_q     <= 1'b0;
      dout_q    <= 8'h00;
      doe_q     <= 1'b0;
      pop_q     <= 1'b0;
      push_q    <= 1'b0;
      wdat_q    <= 8'h00;
      val_q     <= 1'b0;
      bsel_q    <= flyby_dma_pkg::EP_ZERO;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
      lbo_q     <= 16'h0000;
      lbe_q     <= 16'h0000;
    end else begin
      sync1_q   <= '{ack_n: dma_acknowledge_in_n, term_n: end_of_transfer_in_n,
                     hrd_n: host_read_strobe_n, hwr_n: host_write_strobe_n,
                     drd_n: split_dma_read_strobe_n, dwr_n: split_dma_write_strobe_n,
                     data: local_data_bus_in};
      sync2_q   <= sync1_q;
      ctrl_q    <= ctrl_d;
      cfg_q     <= cfg_d;
      state_q   <= state_d;
      page_q    <= page_d;
      split_q   <= split_d;
      cnt_q     <= cnt_d;
      pkt_q     <= pkt_d;
      gap_q     <= gap_d;
      done_q    <= done_d;
      term_q    <= term_d;
      req_q     <= req_d;
      dout_q    <= dout_d;
      doe_q     <= doe_d;
      pop_q     <= pop_d;
      push_q    <= push_d;
      wdat_q    <= wdat_d;
      val_q     <= val_d;
      bsel_q    <= bsel_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
      lbo_q     <= lbo_d;
      lbe_q     <= lbe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from flops except the constant hreadyout and hresp
  assign hrdata             = rdata_q;
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign dma_request_out    = req_q;
  assign local_data_bus_out = lbo_q;
  assign local_data_bus_oe  = lbe_q;
  assign buf_sel            = bsel_q;
  assign buf_pop            = pop_q;
  assign buf_push           = push_q;
  assign buf_wdata          = wdat_q;
  assign buf_validate       = val_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_req_gated: assert property (
    req_q |-> $past(ctrl_q.en) && ($past(ctrl_q.ep) inside {2'h1, 2'h2}))
    else $error("Request raised without enable or A/B select");

  chk_req_drop: assert property (
    (state_q == flyby_dma_pkg::S_CYCLE) |=> !req_q)
    else $error("Request still high during a cycle");

  chk_gap_bound: assert property (
    (state_q == flyby_dma_pkg::S_GAP) |-> ##[1:4] (state_q == flyby_dma_pkg::S_IDLE))
    else $error("Rearm gap too long");

  chk_rearm_req: assert property (
    (state_q == flyby_dma_pkg::S_IDLE && req_ok && !act) |=> req_q)
    else $error("Request not raised again");

  chk_term_stop: assert property (
    (cycle_end && term_q) |=> !ctrl_q.en && done_q)
    else $error("End-of-transfer did not clear enable and set done");

  chk_cnt_zero: assert property (
    (dma_dec && cnt_q == 16'h0001 && !wr_pend_q) |=> cnt_q == 16'h0000 && !ctrl_q.en && done_q)
    else $error("Counter zero did not end the transfer");

  chk_zero_valid: assert property (
    (wr_pend_q && wr_addr_q == flyby_dma_pkg::OFS_XFER_CNT && hwdata[15:0] == 16'h0000)
      |=> val_q ##1 !val_q)
    else $error("Zero counter write did not validate");

  chk_split_lane: assert property (
    doe_q |-> (local_data_bus_oe == (split_q ? 16'hFF00 : 16'h00FF)))
    else $error("DMA data on the wrong lanes");

  chk_read_dir: assert property (
    (doe_q || pop_q) |-> !$past(dma_cfg.dir_in))
    else $error("Device drove data on an IN endpoint");

  chk_pkt_limit: assert property (
    (push_q && dma_cfg.max_pkt != 11'h000) |-> pkt_q < dma_cfg.max_pkt)
    else $error("Packet grew past max size");

endmodule

// file: tb/dma_ctrl_model.sv
`timescale 1ns/100ps
// Fly-by demand controller: one byte per acknowledge, only while requested
module dma_ctrl_model (
  // Clock
  input  wire logic        hclk,
  // Device side
  input  wire logic        dma_request_out,
  input  wire logic [15:0] local_data_bus_out,
  input  wire logic [15:0] local_data_bus_oe,
  // Scenario control
  input  wire logic [7:0]  n_xfer,
  input  wire logic        use_term,
  input  wire logic        use_strobe,
  input  wire logic        split,
  input  wire logic        dir_in,
  // Pins and results
  output logic             ack_n,
  output logic             term_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             drd_n,
  output logic             dwr_n,
  output logic      [15:0] data_in,
  output logic      [7:0]  n_done,
  output logic      [7:0]  rd_byte,
  output logic             rd_ok,
  output logic      [7:0]  wr_byte
);
  initial begin
    {ack_n, term_n, rd_n, wr_n, drd_n, dwr_n} = 6'h3f;
    data_in = 16'h5a5a;
    n_done = 8'h00;
    rd_byte = 8'h00;
    rd_ok = 1'b0;
    wr_byte = 8'h00;
  end

  always begin
    @(posedge hclk);
    if (dma_request_out === 1'b1 && n_done < n_xfer) begin
      // Random answer delay: prompt or slow
      repeat ($urandom_range(0, 2)) @(posedge hclk);
      wr_byte = 8'($urandom);
      ack_n <= 1'b0;
      term_n <= !(use_term && n_done == n_xfer - 8'h01);
      rd_n <= !(use_strobe && !dir_in && !split);
      wr_n <= !(use_strobe && dir_in && !split);
      drd_n <= !(use_strobe && !dir_in && split);
      dwr_n <= !(use_strobe && dir_in && split);
      if (dir_in)
        data_in <= split ? {wr_byte, ~wr_byte} : {~wr_byte, wr_byte};
      // Held long enough for the device's pin synchronisers
      repeat (4) @(posedge hclk);
      rd_byte <= split ? local_data_bus_out[15:8] : local_data_bus_out[7:0];
      rd_ok <= split ? &local_data_bus_oe[15:8] : &local_data_bus_oe[7:0];
      {ack_n, term_n, rd_n, wr_n, drd_n, dwr_n} <= 6'h3f;
      // Released lanes never keep the last value
      data_in <= ~data_in;
      n_done <= n_done + 8'h01;
    end
  end
endmodule

// file: tb/test_usb_endpoint_flyby_dma_port.sv
`timescale 1ns/100ps
module test_usb_endpoint_flyby_dma_port;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, req_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, bsel;
  logic [2:0]  hsize;
  logic        ack_n, term_n, rd_n, wr_n, drd_n, dwr_n, pop, push, valid;
  logic        use_term, use_strobe, split, dir_in, rd_ok;
  logic [15:0] lbus_in, lbus_out, lbus_oe, data_in;
  logic [3:0]  has_data, has_space;
  logic [7:0]  rdata, wdata, n_xfer, n_done, rd_byte, wr_byte;
  int          fail_count, check_count, n_pop, n_push, n_val;

  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  assign lbus_in = (lbus_oe & lbus_out) | (~lbus_oe & data_in);

  usb_endpoint_flyby_dma_port usb_endpoint_flyby_dma_port_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dma_request_out(req_pin),
    .dma_acknowledge_in_n(ack_n), .end_of_transfer_in_n(term_n),
    .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
    .split_dma_read_strobe_n(drd_n), .split_dma_write_strobe_n(dwr_n),
    .local_data_bus_in(lbus_in), .local_data_bus_out(lbus_out), .local_data_bus_oe(lbus_oe),
    .buf_has_data(has_data), .buf_has_space(has_space), .buf_rdata(rdata),
    .buf_sel(bsel), .buf_pop(pop), .buf_push(push), .buf_wdata(wdata),
    .buf_validate(valid));

  dma_ctrl_model dma_ctrl_model_inst (
    .hclk(hclk), .dma_request_out(req_pin), .local_data_bus_out(lbus_out),
    .local_data_bus_oe(lbus_oe), .n_xfer(n_xfer), .use_term(use_term),
    .use_strobe(use_strobe), .split(split), .dir_in(dir_in), .ack_n(ack_n),
    .term_n(term_n), .rd_n(rd_n), .wr_n(wr_n), .drd_n(drd_n), .dwr_n(dwr_n),
    .data_in(data_in), .n_done(n_done), .rd_byte(rd_byte), .rd_ok(rd_ok),
    .wr_byte(wr_byte));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] req_word(logic q, logic [1:0] ep, logic en);
    return {28'h000_0000, q, ep, en};
  endfunction

  function automatic logic [31:0] cfg_word(logic [10:0] mp, logic dir);
    return {20'h0_0000, mp, dir};
  endfunction

  function automatic logic [31:0] n_pkts(int cnt, int mp);
    return 32'((cnt + mp - 1) / mp);
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  // Counters cleared off the edge so the monitor never races the clear
  task automatic clr();
    @(negedge hclk);
    n_pop = 0;
    n_push = 0;
    n_val = 0;
    @(posedge hclk);
  endtask

  task automatic go(input int n, input logic e, input logic s);
    logic [7:0] t;
    t = n_done + 8'(n);
    n_xfer <= t;
    use_term <= e;
    use_strobe <= s;
    for (int i = 0; i < 300 && n_done !== t; i++) @(posedge hclk);
    chk("cycles", 32'(t), 32'(n_done));
    repeat (12) @(posedge hclk);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (pop === 1'b1) n_pop++;
    if (valid === 1'b1) n_val++;
    if (push === 1'b1) begin
      n_push++;
      chk("push data", 32'(wr_byte), 32'(wdata));
    end
  end

  initial begin
    repeat (30000) @(posedge hclk);
    fail_count++;
    $display("ERROR watchdog expected end seen timeout");
    test_done();
  end

  initial begin
    {hclk, hresetn, hsel, hwrite, use_term, use_strobe, split, dir_in} = 8'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    {has_data, has_space, rdata, n_xfer} = 24'h00_0000;
    void'($urandom(32'hf0c5_efcd));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rchk("req reset", flyby_dma_pkg::OFS_DMA_REQ, 32'h0000_0000);
    rchk("cfg reset", flyby_dma_pkg::OFS_EP_SETUP,
         cfg_word(flyby_dma_pkg::RST_MAX_PKT, 1'b0));
    rchk("xfer reset", flyby_dma_pkg::OFS_XFER_CNT, 32'(flyby_dma_pkg::RST_XFER));
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    rchk("unmapped", 8'h40, 32'h0000_0000);
    // Endpoint 0 and C never request; A stays quiet while disabled
    has_data <= 4'hf;
    has_space <= 4'hf;
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ,
          req_word(1'b0, (i == 0) ? flyby_dma_pkg::EP_ZERO :
                         (i == 1) ? flyby_dma_pkg::EP_C : flyby_dma_pkg::EP_A, i != 2));
      repeat (20) @(posedge hclk);
      chk("idle request", 32'h0, 32'(req_pin));
    end
    ahb(1'b1, flyby_dma_pkg::OFS_PAGE_SEL, 32'(flyby_dma_pkg::EP_B));
    ahb(1'b1, flyby_dma_pkg::OFS_EP_SETUP, cfg_word(11'h003, 1'b1));
    chk("sel page", 32'(flyby_dma_pkg::EP_B), 32'(bsel));
    ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ, req_word(1'b0, flyby_dma_pkg::EP_A, 1'b1));
    repeat (2) @(posedge hclk);
    chk("sel dma", 32'(flyby_dma_pkg::EP_A), 32'(bsel));
    rchk("cfg page", flyby_dma_pkg::OFS_EP_SETUP, cfg_word(11'h003, 1'b1));
    ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ, 32'h0000_0000);
    // Read direction over every strobe mode and lane mode
    ahb(1'b1, flyby_dma_pkg::OFS_PAGE_SEL, 32'(flyby_dma_pkg::EP_A));
    ahb(1'b1, flyby_dma_pkg::OFS_EP_SETUP, cfg_word(11'h040, 1'b0));
    for (int i = 0; i < 4; i++) begin
      split <= i[0];
      rdata <= 8'($urandom);
      ahb(1'b1, flyby_dma_pkg::OFS_LOC_CTL, 32'(i & 1));
      ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ, req_word(i[1], flyby_dma_pkg::EP_A, 1'b1));
      clr();
      go(3, 1'b1, 1'b1);
      chk("pops", 32'h3, 32'(n_pop));
      chk("read byte", 32'(rdata), 32'(rd_byte));
      chk("lane", 32'h1, 32'(rd_ok));
      rchk("done", flyby_dma_pkg::OFS_IRQ_STAT, 32'h1);
      rchk("en clear", flyby_dma_pkg::OFS_DMA_REQ, req_word(i[1], flyby_dma_pkg::EP_A, 1'b0));
      ahb(1'b1, flyby_dma_pkg::OFS_IRQ_STAT, 32'h1);
    end
    // Qualified mode refuses an acknowledge without strobe
    split <= 1'b0;
    ahb(1'b1, flyby_dma_pkg::OFS_LOC_CTL, 32'h0);
    ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ, req_word(1'b1, flyby_dma_pkg::EP_A, 1'b1));
    clr();
    go(1, 1'b0, 1'b0);
    chk("no strobe", 32'h0, 32'(n_pop));
    ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ, 32'h0000_0000);
    // Write direction ended by the byte counter
    dir_in <= 1'b1;
    ahb(1'b1, flyby_dma_pkg::OFS_PAGE_SEL, 32'(flyby_dma_pkg::EP_B));
    ahb(1'b1, flyby_dma_pkg::OFS_XFER_CNT, 32'h4);
    ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ, req_word(1'b0, flyby_dma_pkg::EP_B, 1'b1));
    clr();
    go(4, 1'b0, 1'b1);
    chk("pushes", 32'h4, 32'(n_push));
    chk("packets", n_pkts(4, 3), 32'(n_val));
    chk("req after count", 32'h0, 32'(req_pin));
    rchk("done in", flyby_dma_pkg::OFS_IRQ_STAT, 32'h1);
    rchk("en zero", flyby_dma_pkg::OFS_DMA_REQ, req_word(1'b0, flyby_dma_pkg::EP_B, 1'b0));
    ahb(1'b1, flyby_dma_pkg::OFS_IRQ_STAT, 32'h1);
    rchk("done w1c", flyby_dma_pkg::OFS_IRQ_STAT, 32'h0);
    // Write direction ended by end-of-transfer
    ahb(1'b1, flyby_dma_pkg::OFS_XFER_CNT, 32'ha);
    ahb(1'b1, flyby_dma_pkg::OFS_DMA_REQ, req_word(1'b0, flyby_dma_pkg::EP_B, 1'b1));
    clr();
    go(2, 1'b1, 1'b1);
    chk("term pushes", 32'h2, 32'(n_push));
    chk("term valid", 32'h1, 32'(n_val));
    rchk("term done", flyby_dma_pkg::OFS_IRQ_STAT, 32'h1);
    rchk("term en", flyby_dma_pkg::OFS_DMA_REQ, req_word(1'b0, flyby_dma_pkg::EP_B, 1'b0));
    // Software validation by a zero count
    clr();
    ahb(1'b1, flyby_dma_pkg::OFS_XFER_CNT, 32'h0);
    repeat (3) @(posedge hclk);
    chk("zero valid", 32'h1, 32'(n_val));
    test_done();
  end
endmodule
